/* File: include/pps_pkg.sv */
`default_nettype none
package pps_pkg;

  // ************************************************************
  // Receive status codes
  // ************************************************************
  localparam logic [2:0] ST_OK      = 3'h0;
  localparam logic [2:0] ST_SKP_ADD = 3'h1;
  localparam logic [2:0] ST_SKP_DEL = 3'h2;
  localparam logic [2:0] ST_RXDET   = 3'h3;
  localparam logic [2:0] ST_DEC_ERR = 3'h4;
  localparam logic [2:0] ST_OVFL    = 3'h5;
  localparam logic [2:0] ST_UNFL    = 3'h6;
  localparam logic [2:0] ST_DISP    = 3'h7;

  // ************************************************************
  // Idle inference selector values
  // ************************************************************
  localparam logic [2:0] SEL_NORMAL    = 3'h4;
  localparam logic [2:0] SEL_RCV_CFG   = 3'h5;
  localparam logic [2:0] SEL_SPD_FAIL  = 3'h6;
  localparam logic [2:0] SEL_LOOPBACK  = 3'h7;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_PS  = 5000;
  localparam int UI_PS          = 400;
  localparam int TS_WINDOW_UI   = 1280;
  localparam int EXIT_WINDOW_UI = 2000;
  localparam int LONG_WINDOW_US = 128;
  localparam int FR_MIN_NS      = 16;
  localparam int FR_MAX_NS      = 4000;
  localparam int CNT_W          = 15;
  localparam int FR_CNT_W       = 10;
  // Windows are longest times: round down
  localparam logic [CNT_W-1:0] TS_WINDOW_CYC =
    CNT_W'((TS_WINDOW_UI * UI_PS) / CLK_PERIOD_PS);
  localparam logic [CNT_W-1:0] EXIT_WINDOW_CYC =
    CNT_W'((EXIT_WINDOW_UI * UI_PS) / CLK_PERIOD_PS);
  localparam int LONG_WINDOW_CYC = (LONG_WINDOW_US * 1000000) / CLK_PERIOD_PS;
  // Settle is a least time: round up
  localparam logic [FR_CNT_W-1:0] FR_SETTLE_CYC =
    FR_CNT_W'((FR_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [FR_CNT_W-1:0] FR_MAX_CYC =
    FR_CNT_W'((FR_MAX_NS * 1000) / CLK_PERIOD_PS);

  // ************************************************************
  // Registers
  // ************************************************************
  localparam logic [3:0] REG_CTRL     = 4'h0;
  localparam logic [3:0] REG_STAT     = 4'h1;
  localparam int         CTRL_FR_BIT  = 0;
  localparam int         CTRL_EII_BIT = 1;
  localparam logic [7:0] CTRL_RST     = 8'h00;
  localparam int         STAT_REF_BIT  = 3;
  localparam int         STAT_DATA_BIT = 4;
  localparam int         STAT_IDLE_BIT = 5;
  localparam int         STAT_EIOS_BIT = 6;

  typedef enum logic [1:0] {FR_DATA, FR_REF, FR_SETTLE} pps_fr_state_t;

endpackage : pps_pkg
`default_nettype wire

/* File: include/pps_idle_if.sv */
`default_nettype none
interface pps_idle_if;
  logic       enable;
  logic [2:0] sel;
  logic       fc_skp_seen;
  logic       ts_seen;
  logic       sig_present;
  logic       eios_idle;
  logic       idle;

  modport infer (input enable, sel, fc_skp_seen, ts_seen, sig_present, eios_idle,
                 output idle);
  modport ctrl  (output enable, sel, fc_skp_seen, ts_seen, sig_present, eios_idle,
                 input idle);
endinterface : pps_idle_if
`default_nettype wire

/* File: logic/pps_idle_infer.sv */
`default_nettype none
module pps_idle_infer #(
  parameter int LONG_CYC = pps_pkg::LONG_WINDOW_CYC
) (
  input  wire logic   clk,
  input  wire logic   rst,
  pps_idle_if.infer   ii
);

  localparam logic [pps_pkg::CNT_W-1:0] LONG_LIM = pps_pkg::CNT_W'(LONG_CYC);

  logic [pps_pkg::CNT_W-1:0] cnt_q;
  logic [pps_pkg::CNT_W-1:0] limit;
  logic [2:0]                sel_q;
  logic                      hit;
  logic                      idle_q;

  // ************************************************************
  // Window selection
  // ************************************************************
  // Exit is the analog signal-present level; exit ordered sets are not looked at
  always_comb
  begin
    hit   = 1'b0;
    limit = LONG_LIM;
    case (ii.sel)
      pps_pkg::SEL_NORMAL:
      begin
        hit   = ii.fc_skp_seen;
        limit = LONG_LIM;
      end
      pps_pkg::SEL_RCV_CFG:
      begin
        hit   = ii.ts_seen;
        limit = pps_pkg::TS_WINDOW_CYC;
      end
      pps_pkg::SEL_SPD_FAIL:
      begin
        hit   = ii.sig_present;
        limit = pps_pkg::EXIT_WINDOW_CYC;
      end
      pps_pkg::SEL_LOOPBACK:
      begin
        hit   = ii.sig_present;
        limit = LONG_LIM;
      end
      default:
      begin
        hit   = 1'b0;
        limit = LONG_LIM;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      sel_q <= 3'h0;
    else
      sel_q <= ii.sel;
  end

  // Counter restarts when the substate changes, so a stale window never fires
  always_ff @(posedge clk)
  begin
    if (rst || !ii.enable || !ii.sel[2] || hit || ii.sel != sel_q)
      cnt_q <= '0;
    else if (cnt_q != limit)
      cnt_q <= cnt_q + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      idle_q <= 1'b0;
    else if (!ii.enable)
      idle_q <= !ii.sig_present;
    else if (!ii.sel[2])
      idle_q <= ii.eios_idle;
    else
      idle_q <= !hit && ii.sel == sel_q && cnt_q == limit;
  end

  assign ii.idle = idle_q;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_idle_follows_sigdet: assert property (
    !ii.enable |=> ii.idle == !$past(ii.sig_present))
    else $error("idle not inverted signal-present while inference off");
  a_idle_ts_clears: assert property (
    ii.enable && ii.sel == pps_pkg::SEL_RCV_CFG && ii.ts_seen |=> !ii.idle)
    else $error("idle raised although a training set arrived");
  a_idle_eios_path: assert property (
    ii.enable && !ii.sel[2] |=> ii.idle == $past(ii.eios_idle))
    else $error("idle does not follow eios detection");
  c_idle_ts_timeout: cover property (
    ii.enable && ii.sel == pps_pkg::SEL_RCV_CFG && ii.idle);

endmodule : pps_idle_infer
`default_nettype wire

/* File: logic/pps_pipe_status.sv */
`default_nettype none
module pps_pipe_status #(
  parameter int LONG_CYC = pps_pkg::LONG_WINDOW_CYC,
  parameter bit WIDTH16  = 1'b1
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [7:0]  reg_rdata_q,
  input  wire logic [15:0] tx_data_in,
  input  wire logic [1:0]  tx_datak_in,
  input  wire logic [1:0]  tx_force_disp_in,
  output var  logic [15:0] tx_data_q,
  output var  logic [1:0]  tx_datak_q,
  output var  logic [1:0]  tx_neg_disp_q,
  input  wire logic        dec_err,
  input  wire logic        rm_ovfl,
  input  wire logic        rm_unfl,
  input  wire logic        disp_err,
  input  wire logic        skp_add,
  input  wire logic        skp_del,
  input  wire logic        rxdet_done,
  input  wire logic        rxdet_found,
  output var  logic [2:0]  status_q,
  input  wire logic        eios_det,
  input  wire logic        nfts_det,
  input  wire logic        signal_present,
  input  wire logic        lock_reference_mode_in,
  input  wire logic        lock_data_mode_in,
  output var  logic        lock_reference_mode_q,
  output var  logic        lock_data_mode_q,
  input  wire logic [2:0]  idle_sel,
  input  wire logic        fc_skp_seen,
  input  wire logic        ts_seen,
  output var  logic        inferred_idle_q
);

  logic [7:0]                   ctrl_q;
  logic                         sigp_meta_q;
  logic                         sigp_q;
  logic                         eios_idle_q;
  pps_pkg::pps_fr_state_t       fr_state_q;
  logic [pps_pkg::FR_CNT_W-1:0] fr_cnt_q;
  logic [2:0]                   status_d;
  logic                         fr_en;
  logic                         eii_en;

  pps_idle_if ii ();

  assign fr_en  = ctrl_q[pps_pkg::CTRL_FR_BIT];
  assign eii_en = ctrl_q[pps_pkg::CTRL_EII_BIT];

  // ************************************************************
  // Register port
  // ************************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
      ctrl_q <= pps_pkg::CTRL_RST;
    else if (reg_wr && reg_addr == pps_pkg::REG_CTRL)
      ctrl_q <= reg_wdata;
  end

  // Unmapped addresses read as zero
  always_ff @(posedge clk)
  begin
    if (rst || !reg_rd)
      reg_rdata_q <= 8'h00;
    else
      case (reg_addr)
        pps_pkg::REG_CTRL:
          reg_rdata_q <= ctrl_q;
        pps_pkg::REG_STAT:
          reg_rdata_q <= {1'b0, eios_idle_q, inferred_idle_q, lock_data_mode_q,
                          lock_reference_mode_q, status_q};
        default:
          reg_rdata_q <= 8'h00;
      endcase
  end

  // ************************************************************
  // Compliance disparity
  // ************************************************************
  // Upper lane force is ignored in 8-bit mode; the encoder sees only lane 0
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tx_data_q     <= 16'h0000;
      tx_datak_q    <= 2'h0;
      tx_neg_disp_q <= 2'h0;
    end
    else
    begin
      tx_data_q     <= tx_data_in;
      tx_datak_q    <= tx_datak_in;
      tx_neg_disp_q <= {tx_force_disp_in[1] & WIDTH16, tx_force_disp_in[0]};
    end
  end

  // ************************************************************
  // Receive status
  // ************************************************************
  function automatic logic [2:0] encode_status(
    input logic dec, input logic ovf, input logic unf, input logic dsp,
    input logic add, input logic del, input logic det_done, input logic det_found);
    logic [2:0] code;
    code = pps_pkg::ST_OK;
    if (dec)
      code = pps_pkg::ST_DEC_ERR;
    else if (ovf)
      code = pps_pkg::ST_OVFL;
    else if (unf)
      code = pps_pkg::ST_UNFL;
    else if (dsp)
      code = pps_pkg::ST_DISP;
    else if (add)
      code = pps_pkg::ST_SKP_ADD;
    else if (del)
      code = pps_pkg::ST_SKP_DEL;
    else if (det_done && det_found)
      code = pps_pkg::ST_RXDET;
    if (3'(dec) + 3'(ovf) + 3'(unf) + 3'(dsp) >= 3'd2)
      code = pps_pkg::ST_DEC_ERR;
    return code;
  endfunction : encode_status

  assign status_d = encode_status(dec_err, rm_ovfl, rm_unfl, disp_err,
                                  skp_add, skp_del, rxdet_done, rxdet_found);

  always_ff @(posedge clk)
  begin
    if (rst)
      status_q <= pps_pkg::ST_OK;
    else
      status_q <= status_d;
  end

  // ************************************************************
  // Signal present synchroniser
  // ************************************************************
  // Reset as present: an absent reset level would fake idle after reset
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sigp_meta_q <= 1'b1;
      sigp_q      <= 1'b1;
    end
    else
    begin
      sigp_meta_q <= signal_present;
      sigp_q      <= sigp_meta_q;
    end
  end

  // ************************************************************
  // Fast recovery
  // ************************************************************
  // Reference lock holds frequency while the line is idle, so data lock
  // after standby needs only phase: that is what keeps the 4 us budget
  always_ff @(posedge clk)
  begin
    if (rst || !fr_en)
    begin
      fr_state_q <= pps_pkg::FR_DATA;
      fr_cnt_q   <= '0;
    end
    else
      case (fr_state_q)
        pps_pkg::FR_DATA:
        begin
          fr_cnt_q <= '0;
          if (eios_det)
            fr_state_q <= pps_pkg::FR_REF;
        end
        pps_pkg::FR_REF:
        begin
          fr_cnt_q <= '0;
          if (sigp_q)
            fr_state_q <= pps_pkg::FR_SETTLE;
        end
        pps_pkg::FR_SETTLE:
        begin
          fr_cnt_q <= fr_cnt_q + 1'b1;
          if (!sigp_q)
            fr_state_q <= pps_pkg::FR_REF;
          else if ((nfts_det && fr_cnt_q >= pps_pkg::FR_SETTLE_CYC - 1'b1)
                   || fr_cnt_q == pps_pkg::FR_MAX_CYC - 1'b1)
            fr_state_q <= pps_pkg::FR_DATA;
        end
        default:
        begin
          fr_state_q <= pps_pkg::FR_DATA;
          fr_cnt_q   <= '0;
        end
      endcase
  end

  // Manual controls pass only while fast recovery is off
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      lock_reference_mode_q <= 1'b0;
      lock_data_mode_q      <= 1'b0;
    end
    else if (fr_en)
    begin
      lock_reference_mode_q <= fr_state_q != pps_pkg::FR_DATA;
      lock_data_mode_q      <= fr_state_q == pps_pkg::FR_DATA;
    end
    else
    begin
      lock_reference_mode_q <= lock_reference_mode_in;
      lock_data_mode_q      <= lock_data_mode_in;
    end
  end

  // EIOS seen wins over any clearing event in the same cycle
  always_ff @(posedge clk)
  begin
    if (rst)
      eios_idle_q <= 1'b0;
    else if (eios_det)
      eios_idle_q <= 1'b1;
    else if (nfts_det || ts_seen || fc_skp_seen)
      eios_idle_q <= 1'b0;
  end

  // ************************************************************
  // Idle inference
  // ************************************************************
  assign ii.enable      = eii_en;
  assign ii.sel         = idle_sel;
  assign ii.fc_skp_seen = fc_skp_seen;
  assign ii.ts_seen     = ts_seen;
  assign ii.sig_present = sigp_q;
  assign ii.eios_idle   = eios_idle_q;
  assign inferred_idle_q = ii.idle;

  pps_idle_infer #(
    .LONG_CYC (LONG_CYC)
  ) u_idle (
    .clk (clk),
    .rst (rst),
    .ii  (ii.infer)
  );

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_status_decode_first: assert property (
    dec_err |=> status_q == pps_pkg::ST_DEC_ERR)
    else $error("decode error not reported first");
  a_status_multi_err: assert property (
    !dec_err && rm_ovfl && disp_err |=> status_q == pps_pkg::ST_DEC_ERR)
    else $error("multiple errors not reported as decode error");
  a_status_skp_order: assert property (
    !dec_err && !rm_ovfl && !rm_unfl && !disp_err && skp_add && skp_del
    |=> status_q == pps_pkg::ST_SKP_ADD)
    else $error("skp added must outrank skp removed");
  a_status_underflow: assert property (
    !dec_err && !rm_ovfl && rm_unfl && !disp_err |=> status_q == pps_pkg::ST_UNFL)
    else $error("underflow code wrong");
  a_force_neg_disp: assert property (
    tx_force_disp_in[0] |=> tx_neg_disp_q[0] && tx_data_q == $past(tx_data_in))
    else $error("forced disparity not passed with its symbol");
  a_fr_eios_ref: assert property (
    fr_en && fr_state_q == pps_pkg::FR_DATA && eios_det ##1 fr_en
    |=> lock_reference_mode_q && !lock_data_mode_q)
    else $error("eios did not force reference lock");
  a_fr_settle_bound: assert property (
    fr_state_q == pps_pkg::FR_SETTLE |-> fr_cnt_q < pps_pkg::FR_MAX_CYC)
    else $error("data lock not reached within the recovery limit");
  a_fr_manual_ignored: assert property (
    fr_en && $stable(fr_en) && fr_state_q == pps_pkg::FR_DATA
    |=> lock_data_mode_q && !lock_reference_mode_q)
    else $error("manual lock control leaked through fast recovery");

  c_multi_err: cover property (dec_err && rm_unfl);
  c_fr_cycle: cover property (
    fr_state_q == pps_pkg::FR_SETTLE ##1 fr_state_q == pps_pkg::FR_DATA);
  c_rxdet: cover property (status_q == pps_pkg::ST_RXDET);

endmodule : pps_pipe_status
`default_nettype wire

/* File: test/pps_fabric_model.sv */
`default_nettype none
module pps_fabric_model #(
  parameter bit W16 = 1'b1
) (
  input  wire logic        clk,
  input  wire logic        run,
  output var  logic [15:0] tx_data,
  output var  logic [1:0]  tx_datak,
  output var  logic [1:0]  tx_force
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // Compliance pattern source, lane 0 in the low byte
  // ************************************************************
  logic [1:0] ph_q;

  initial
  begin
    ph_q = 2'h0;
    tx_data = 16'h0000;
    tx_datak = 2'h0;
    tx_force = 2'h0;
  end

  always @(posedge clk)
  begin
    if (!run)
    begin
      ph_q <= 2'h0;
      tx_data <= 16'h0000;
      tx_datak <= 2'h0;
      tx_force <= 2'h0;
    end
    else if (W16)
    begin
      ph_q <= ph_q ^ 2'h1;
      tx_data <= ph_q[0] ? 16'h4abc : 16'hb5bc;
      tx_datak <= 2'h1;
      tx_force <= ph_q[0] ? 2'h0 : 2'h1;
    end
    else
    begin
      ph_q <= ph_q + 2'h1;
      tx_data <= {8'h00, ph_q[0] ? (ph_q[1] ? 8'h4a : 8'hb5) : 8'hbc};
      tx_datak <= {1'b0, !ph_q[0]};
      tx_force <= {1'b0, ph_q == 2'h0};
    end
  end
endmodule : pps_fabric_model
`default_nettype wire

/* File: test/pps_pipe_status_bench.sv */
`default_nettype none
module pps_pipe_status_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LC = 50;
  logic        clk, rst, reg_wr, reg_rd, run, dec_err, rm_ovfl, rm_unfl, disp_err;
  logic        skp_add, skp_del, rxdet_done, rxdet_found, eios_det, nfts_det;
  logic        signal_present, lock_reference_mode_in, lock_data_mode_in;
  logic        fc_skp_seen, ts_seen, inferred_idle_q;
  logic        lock_reference_mode_q, lock_data_mode_q;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata_q;
  logic [15:0] tx_data_in, tx_data_q;
  logic [1:0]  tx_datak_in, tx_force_disp_in, tx_datak_q, tx_neg_disp_q;
  logic [2:0]  status_q, idle_sel;
  logic [15:0] tx8_data, tx8_q;
  logic [1:0]  tx8_k, tx8_f, tx8_kq, tx8_nd;
  int          n_errors, checked;
  logic [6:0]  ev_in [14] = '{7'h00, 7'h04, 7'h02, 7'h01, 7'h40, 7'h20, 7'h10,
                              7'h08, 7'h06, 7'h0c, 7'h30, 7'h18, 7'h50, 7'h28};
  logic [2:0]  ev_exp [14] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6,
                               3'h7, 3'h1, 3'h7, 3'h4, 3'h4, 3'h4, 3'h4};

  pps_pipe_status #(.LONG_CYC(LC), .WIDTH16(1'b1)) pps_pipe_status_inst (
    .clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q,
    .tx_data_in, .tx_datak_in, .tx_force_disp_in, .tx_data_q, .tx_datak_q,
    .tx_neg_disp_q, .dec_err, .rm_ovfl, .rm_unfl, .disp_err, .skp_add, .skp_del,
    .rxdet_done, .rxdet_found, .status_q, .eios_det, .nfts_det, .signal_present,
    .lock_reference_mode_in, .lock_data_mode_in, .lock_reference_mode_q,
    .lock_data_mode_q, .idle_sel, .fc_skp_seen, .ts_seen, .inferred_idle_q);

  pps_fabric_model #(.W16(1'b1)) pps_fabric_model_inst (
    .clk, .run, .tx_data(tx_data_in), .tx_datak(tx_datak_in), .tx_force(tx_force_disp_in));

  // Eight-bit lane width: only the transmit side is looked at
  pps_pipe_status #(.LONG_CYC(LC), .WIDTH16(1'b0)) pps_pipe_status_w8_inst (
    .clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q(),
    .tx_data_in(tx8_data), .tx_datak_in(tx8_k), .tx_force_disp_in(tx8_f),
    .tx_data_q(tx8_q), .tx_datak_q(tx8_kq), .tx_neg_disp_q(tx8_nd), .dec_err, .rm_ovfl,
    .rm_unfl, .disp_err, .skp_add, .skp_del, .rxdet_done, .rxdet_found, .status_q(),
    .eios_det, .nfts_det, .signal_present, .lock_reference_mode_in, .lock_data_mode_in,
    .lock_reference_mode_q(), .lock_data_mode_q(), .idle_sel, .fc_skp_seen, .ts_seen,
    .inferred_idle_q());

  pps_fabric_model #(.W16(1'b0)) pps_fabric_model_w8_inst (
    .clk, .run, .tx_data(tx8_data), .tx_datak(tx8_k), .tx_force(tx8_f));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ************************************************************
  // Access and check tasks
  // ************************************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata_q, exp);
  endtask : rd

  task automatic ev(input logic [6:0] b, input logic [2:0] exp);
    @(posedge clk);
    {dec_err, rm_ovfl, rm_unfl, disp_err, skp_add, skp_del, rxdet_found} <= b;
    rxdet_done <= b[0];
    @(posedge clk);
    {dec_err, rm_ovfl, rm_unfl, disp_err, skp_add, skp_del, rxdet_found} <= 7'h00;
    rxdet_done <= 1'b0;
    #1 chk(status_q, exp);
  endtask : ev

  task automatic pulse(input logic [3:0] m);
    @(posedge clk);
    {eios_det, nfts_det, ts_seen, fc_skp_seen} <= m;
    @(posedge clk);
    {eios_det, nfts_det, ts_seen, fc_skp_seen} <= 4'h0;
  endtask : pulse

  // Bounded wait on idle (w=0) or data lock (w=1), then compare
  task automatic await(input int w, input logic v, input int maxc);
    int k = 0;
    while ((w ? lock_data_mode_q : inferred_idle_q) !== v && k < maxc)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    chk(w ? lock_data_mode_q : inferred_idle_q, v);
  endtask : await

  // Early check leaves room for the two synchroniser stages
  task automatic exit_win(input logic [2:0] s, input int n);
    @(posedge clk);
    idle_sel <= s;
    signal_present <= 1'b0;
    repeat (n - 4) @(posedge clk);
    #1 chk(inferred_idle_q, 1'b0);
    await(0, 1'b1, 14);
    @(posedge clk);
    signal_present <= 1'b1;
    await(0, 1'b0, 6);
  endtask : exit_win

  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize

  initial
  begin
    #100000;
    n_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    summarize();
  end

  // ************************************************************
  // Test sequence
  // ************************************************************
  initial
  begin
    logic [15:0] d, d8;
    {rst, run, signal_present, lock_reference_mode_in} = 4'hf;
    {reg_wr, reg_rd, dec_err, rm_ovfl, rm_unfl, disp_err, skp_add, skp_del} = 8'h00;
    {rxdet_done, rxdet_found, eios_det, nfts_det, fc_skp_seen, ts_seen} = 6'h00;
    {run, lock_data_mode_in, reg_addr, reg_wdata, idle_sel} = '0;
    n_errors = 0;
    checked = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 chk(status_q, 3'h0);
    chk(inferred_idle_q, 1'b0);
    rd(pps_pkg::REG_CTRL, pps_pkg::CTRL_RST);
    rd(4'h9, 8'h00);
    $display("test reset done");
    foreach (ev_in[i]) ev(ev_in[i], ev_exp[i]);
    $display("test status done");
    @(posedge clk);
    run <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    for (int i = 0; i < 8; i++)
    begin
      d = tx_data_in;
      d8 = tx8_data;
      @(posedge clk);
      #1 chk(tx_data_q, d);
      chk(tx_neg_disp_q, {1'b0, i % 2 == 0});
      chk(tx_datak_q, 2'h1);
      chk(tx8_q, d8);
      chk(tx8_kq, {1'b0, i % 2 == 0});
      chk(tx8_nd, {1'b0, i % 4 == 2});
    end
    run <= 1'b0;
    $display("test compliance done");
    @(posedge clk);
    signal_present <= 1'b0;
    await(0, 1'b1, 6);
    @(posedge clk);
    signal_present <= 1'b1;
    await(0, 1'b0, 6);
    wr(pps_pkg::REG_CTRL, 8'h02);
    pulse(4'h8);
    await(0, 1'b1, 4);
    rd(pps_pkg::REG_STAT, 8'h68);
    pulse(4'h4);
    await(0, 1'b0, 4);
    $display("test idle follow done");
    @(posedge clk);
    idle_sel <= pps_pkg::SEL_RCV_CFG;
    pulse(4'h2);
    repeat (int'(pps_pkg::TS_WINDOW_CYC) - 6) @(posedge clk);
    #1 chk(inferred_idle_q, 1'b0);
    await(0, 1'b1, 12);
    pulse(4'h2);
    await(0, 1'b0, 3);
    @(posedge clk);
    idle_sel <= pps_pkg::SEL_NORMAL;
    repeat (5)
    begin
      repeat (30) @(posedge clk);
      pulse(4'h1);
    end
    #1 chk(inferred_idle_q, 1'b0);
    repeat (LC - 6) @(posedge clk);
    #1 chk(inferred_idle_q, 1'b0);
    await(0, 1'b1, 12);
    @(posedge clk);
    idle_sel <= pps_pkg::SEL_SPD_FAIL;
    repeat (170) @(posedge clk);
    #1 chk(inferred_idle_q, 1'b0);
    exit_win(pps_pkg::SEL_SPD_FAIL, int'(pps_pkg::EXIT_WINDOW_CYC));
    exit_win(pps_pkg::SEL_LOOPBACK, LC);
    $display("test idle windows done");
    wr(pps_pkg::REG_CTRL, 8'h03);
    repeat (3) @(posedge clk);
    #1 chk(lock_reference_mode_q, 1'b0);
    chk(lock_data_mode_q, 1'b1);
    pulse(4'h8);
    await(1, 1'b0, 4);
    chk(lock_reference_mode_q, 1'b1);
    repeat (10) @(posedge clk);
    pulse(4'h4);
    await(1, 1'b1, 4);
    pulse(4'h8);
    await(1, 1'b0, 4);
    await(1, 1'b1, int'(pps_pkg::FR_MAX_CYC) + 10);
    $display("test fast recovery done");
    summarize();
  end
endmodule : pps_pipe_status_bench
`default_nettype wire
